// File: rtl/nlo_top.sv
// near-limit flag and offset programming for two fifos, with apb registers
//
// Operation
// - each near-limit flag is high when the word count is at or below x or at or above 512-y.
// - offsets load only between a fifo clear and the first data word written.
// - the first strobe rise with program enable low loads the low data byte into x and y.
// - a second strobe rise with program enable still low reloads y alone from the data byte.
// - each offset is an unsigned eight-bit value of at most 255.
// - with program enable never lowered both offsets stay at 128.
// - strobe rises that load offsets write no word and leave the count alone.
// - fifo b is programmed the same way from its own enable, strobe and low data byte.
// - a fifo clear forces that fifo's near-limit flag high.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "nlo_cfg.svh"
module nlo_top
   import nlo_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`NLO_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]             pwdata,
   output      logic [31:0]             prdata,
   output      logic                    pready,
   output      logic                    pslverr,
   output      logic                    irq,
   input  wire logic                    load_strobe_a,
   input  wire logic                    unload_strobe_a,
   input  wire logic                    offset_prog_enable_n_a,
   input  wire logic                    fifo_a_clear_n,
   input  wire logic [`NLO_OFF_W-1:0]   port_a_low_byte,
   output      logic                    near_limit_flag_a,
   input  wire logic                    load_strobe_b,
   input  wire logic                    unload_strobe_b,
   input  wire logic                    offset_prog_enable_n_b,
   input  wire logic                    fifo_b_clear_n,
   input  wire logic [`NLO_OFF_W-1:0]   port_b_low_byte,
   output      logic                    near_limit_flag_b
);

   // ************************************************************
   // shared signals
   // ************************************************************
   localparam int NCH = `NLO_NCH;

   logic [`NLO_PIN_W-1:0]  pin_raw [NCH];
   logic [`NLO_PIN_W-1:0]  pin_lvl [NCH];
   logic [NCH-1:0]         flag_v;
   logic [NCH-1:0]         open_v;
   logic [NCH-1:0]         ev_flag_v;
   logic [NCH-1:0]         ev_prog_v;
   logic [`NLO_OFF_W-1:0]  x_v     [NCH];
   logic [`NLO_OFF_W-1:0]  y_v     [NCH];
   logic [`NLO_CNT_W-1:0]  cnt_v   [NCH];

   nlo_apb_t               apb_r;
   nlo_apb_t               apb_nxt;

   nlo_if                  irq_bus ();

   // pin order in each vector: byte, clear_n, enable_n, unload, load
   assign pin_raw[0] = {port_a_low_byte, fifo_a_clear_n, offset_prog_enable_n_a,
                        unload_strobe_a, load_strobe_a};
   assign pin_raw[1] = {port_b_low_byte, fifo_b_clear_n, offset_prog_enable_n_b,
                        unload_strobe_b, load_strobe_b};

   // ************************************************************
   // per-fifo channel
   // ************************************************************
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      nlo_chan_t              ch_r;
      nlo_chan_t              ch_nxt;
      logic                   ld;
      logic                   un;
      logic                   pen_n;
      logic                   clearing;
      logic [`NLO_OFF_W-1:0]  dbyte;
      logic                   rise_ld;
      logic                   rise_un;
      logic                   wr_word;
      logic                   inc;
      logic                   dec;
      logic                   prog;
      logic                   near_empty;
      logic                   near_full;

      // the pins cross from the fifo's own timing domain
      // the byte rides the same filter as the strobe so both arrive together
      nlo_sync #(
         .W   (`NLO_PIN_W),
         .RST (`NLO_PIN_RST)
      ) u_sync (
         .pclk    (pclk),
         .presetn (presetn),
         .din     (pin_raw[i]),
         .lvl     (pin_lvl[i])
      );

      assign ld       = pin_lvl[i][0];
      assign un       = pin_lvl[i][1];
      assign pen_n    = pin_lvl[i][2];
      assign clearing = ~pin_lvl[i][3] | apb_r.soft_clr[i];
      assign dbyte    = pin_lvl[i][`NLO_PIN_W-1:4];

      always_comb begin
         ch_nxt        = ch_r;
         ch_nxt.ld_lvl = ld;
         ch_nxt.un_lvl = un;
         rise_ld       = ld & ~ch_r.ld_lvl;
         rise_un       = un & ~ch_r.un_lvl;
         wr_word       = 1'b0;
         prog          = 1'b0;
         if (clearing) begin
            // clear restores defaults and reopens the window
            // strobes seen during a clear are dropped, not held over
            ch_nxt.phase = NLO_OPEN;
            ch_nxt.off_x = `NLO_OFF_DEFAULT;
            ch_nxt.off_y = `NLO_OFF_DEFAULT;
         end else if (rise_ld) begin
            unique case (ch_r.phase)
               NLO_OPEN: begin
                  if (!pen_n) begin
                     // first load sets both offsets
                     ch_nxt.off_x = dbyte;
                     ch_nxt.off_y = dbyte;
                     ch_nxt.phase = NLO_ONE;
                     prog         = 1'b1;
                  end else begin
                     // first data word closes the window
                     wr_word      = 1'b1;
                     ch_nxt.phase = NLO_SHUT;
                  end
               end
               NLO_ONE: begin
                  if (!pen_n) begin
                     // second load replaces y only
                     ch_nxt.off_y = dbyte;
                     ch_nxt.phase = NLO_TWO;
                     prog         = 1'b1;
                  end else begin
                     wr_word      = 1'b1;
                     ch_nxt.phase = NLO_SHUT;
                  end
               end
               NLO_TWO: begin
                  // a third edge with enable still low is swallowed
                  if (pen_n) begin
                     wr_word      = 1'b1;
                     ch_nxt.phase = NLO_SHUT;
                  end
               end
               NLO_SHUT: begin
                  // enable is ignored once data has been stored
                  wr_word = 1'b1;
               end
            endcase
         end
         // the count stops at 512 and at 0 instead of wrapping
         // programming edges never reach the count
         inc = wr_word & (ch_r.cnt != `NLO_DEPTH);
         dec = rise_un & ~clearing & (ch_r.cnt != '0);
         if (clearing) begin
            ch_nxt.cnt = '0;
         end else begin
            ch_nxt.cnt = ch_r.cnt + {{(`NLO_CNT_W-1){1'b0}}, inc}
                                  - {{(`NLO_CNT_W-1){1'b0}}, dec};
         end
         // flag follows the next count so it never lags a cycle
         near_empty  = (ch_nxt.cnt <= {2'b00, ch_nxt.off_x});
         near_full   = (ch_nxt.cnt >= (`NLO_DEPTH - {2'b00, ch_nxt.off_y}));
         ch_nxt.flag = clearing | near_empty | near_full;
         ev_flag_v[i] = ch_nxt.flag & ~ch_r.flag;
         ev_prog_v[i] = prog;
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ch_r.phase  <= NLO_OPEN;
            ch_r.off_x  <= `NLO_OFF_DEFAULT;
            ch_r.off_y  <= `NLO_OFF_DEFAULT;
            ch_r.cnt    <= '0;
            ch_r.flag   <= 1'b1;
            ch_r.ld_lvl <= 1'b0;
            ch_r.un_lvl <= 1'b0;
         end else begin
            ch_r <= ch_nxt;
         end
      end

      assign flag_v[i] = ch_r.flag;
      assign open_v[i] = (ch_r.phase != NLO_SHUT);
      assign x_v[i]    = ch_r.off_x;
      assign y_v[i]    = ch_r.off_y;
      assign cnt_v[i]  = ch_r.cnt;
   end

   // ************************************************************
   // flag outputs
   // ************************************************************
   // both flags leave straight from the channel registers
   assign near_limit_flag_a = flag_v[0];
   assign near_limit_flag_b = flag_v[1];

   // ************************************************************
   // apb slave
   // ************************************************************
   logic setup_ph;
   logic access_ph;
   logic hit;
   logic wr_hit;

   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;

   function automatic logic decode(input logic [`NLO_ADDR_W-1:0] a);
      logic ok;
      ok = 1'b0;
      case (a)
         `NLO_REG_CTRL, `NLO_REG_STATUS, `NLO_REG_OFFS_A, `NLO_REG_OFFS_B,
         `NLO_REG_COUNT_A, `NLO_REG_COUNT_B, `NLO_REG_IRQ_STAT,
         `NLO_REG_IRQ_MASK: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   function automatic logic [31:0] offs_word(input logic [`NLO_OFF_W-1:0] x,
                                             input logic [`NLO_OFF_W-1:0] y);
      logic [31:0] w;
      w = '0;
      w[`NLO_OFFS_X_LSB +: `NLO_OFF_W] = x;
      w[`NLO_OFFS_Y_LSB +: `NLO_OFF_W] = y;
      return w;
   endfunction

   assign hit = decode(paddr);

   // writes land only at the access edge; unmapped writes are dropped
   assign wr_hit = access_ph & pwrite & hit;

   // read data is captured in the setup cycle so prdata comes from a flop
   // and the slave still answers with no wait state
   always_comb begin
      apb_nxt          = apb_r;
      apb_nxt.soft_clr = '0;
      if (setup_ph) begin
         apb_nxt.prdata = '0;
         case (paddr)
            `NLO_REG_STATUS: begin
               apb_nxt.prdata[`NLO_STAT_FLAG_LSB +: NCH] = flag_v;
               apb_nxt.prdata[`NLO_STAT_OPEN_LSB +: NCH] = open_v;
            end
            `NLO_REG_OFFS_A:   apb_nxt.prdata = offs_word(x_v[0], y_v[0]);
            `NLO_REG_OFFS_B:   apb_nxt.prdata = offs_word(x_v[1], y_v[1]);
            `NLO_REG_COUNT_A:  apb_nxt.prdata[`NLO_CNT_W-1:0] = cnt_v[0];
            `NLO_REG_COUNT_B:  apb_nxt.prdata[`NLO_CNT_W-1:0] = cnt_v[1];
            `NLO_REG_IRQ_STAT: apb_nxt.prdata[`NLO_IRQ_W-1:0] = irq_bus.stat;
            `NLO_REG_IRQ_MASK: apb_nxt.prdata[`NLO_IRQ_W-1:0] = irq_bus.mask;
            default:           apb_nxt.prdata = '0;
         endcase
      end
      // soft clear acts for one cycle, like a short pulse on the clear pin
      if (wr_hit && (paddr == `NLO_REG_CTRL)) begin
         apb_nxt.soft_clr = pwdata[NCH-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_r <= '0;
      end else begin
         apb_r <= apb_nxt;
      end
   end

   assign prdata  = apb_r.prdata;
   // every access completes in its first access cycle, no wait states
   assign pready  = 1'b1;
   // misaligned or unmapped addresses answer with an error and read zero
   assign pslverr = access_ph & ~hit;

   // ************************************************************
   // interrupts
   // ************************************************************
   assign irq_bus.ev      = {ev_prog_v, ev_flag_v};
   assign irq_bus.wr_stat = wr_hit & (paddr == `NLO_REG_IRQ_STAT);
   assign irq_bus.wr_mask = wr_hit & (paddr == `NLO_REG_IRQ_MASK);
   assign irq_bus.wdata   = pwdata[`NLO_IRQ_W-1:0];
   assign irq             = irq_bus.irq;

   nlo_irq u_irq (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (irq_bus.irq_side)
   );

endmodule

// File: rtl/nlo_cfg.svh
// constants of the near-limit offset block: register map, fields, reset values
`ifndef NLO_CFG_SVH
`define NLO_CFG_SVH

// ************************************************************
// fifo geometry and offsets
// ************************************************************
`define NLO_NCH             2
`define NLO_CNT_W           10
`define NLO_DEPTH           10'h200
`define NLO_OFF_W           8
`define NLO_OFF_DEFAULT     8'h80
`define NLO_PIN_W           12

// ************************************************************
// apb register map (byte addresses)
// ************************************************************
`define NLO_ADDR_W          8
`define NLO_REG_CTRL        8'h00
`define NLO_REG_STATUS      8'h04
`define NLO_REG_OFFS_A      8'h08
`define NLO_REG_OFFS_B      8'h0C
`define NLO_REG_COUNT_A     8'h10
`define NLO_REG_COUNT_B     8'h14
`define NLO_REG_IRQ_STAT    8'h18
`define NLO_REG_IRQ_MASK    8'h1C

// ************************************************************
// field positions and reset values
// ************************************************************
`define NLO_OFFS_X_LSB      0
`define NLO_OFFS_Y_LSB      8
`define NLO_STAT_FLAG_LSB   0
`define NLO_STAT_OPEN_LSB   2
`define NLO_IRQ_W           4
`define NLO_IRQ_FLAG_LSB    0
`define NLO_IRQ_PROG_LSB    2
`define NLO_PIN_RST         12'h004

`endif

// File: rtl/nlo_pkg.sv
// types shared by the near-limit offset block
package nlo_pkg;
`include "nlo_cfg.svh"

   // programming window: open after clear, one and two offset loads, shut
   typedef enum logic [1:0] {
      NLO_OPEN = 2'b00,
      NLO_ONE  = 2'b01,
      NLO_TWO  = 2'b11,
      NLO_SHUT = 2'b10
   } nlo_phase_t;

   typedef struct packed {
      nlo_phase_t             phase;
      logic [`NLO_OFF_W-1:0]  off_x;
      logic [`NLO_OFF_W-1:0]  off_y;
      logic [`NLO_CNT_W-1:0]  cnt;
      logic                   flag;
      logic                   ld_lvl;
      logic                   un_lvl;
   } nlo_chan_t;

   typedef struct packed {
      logic [31:0]            prdata;
      logic [`NLO_NCH-1:0]    soft_clr;
   } nlo_apb_t;

   typedef struct packed {
      logic [`NLO_IRQ_W-1:0]  stat;
      logic [`NLO_IRQ_W-1:0]  mask;
   } nlo_irq_st_t;

endpackage

// File: rtl/nlo_if.sv
// event and interrupt-register carrier between the top and the interrupt block
`timescale 1ns/1ps
`include "nlo_cfg.svh"
interface nlo_if;
   logic [`NLO_IRQ_W-1:0] ev;
   logic                  wr_stat;
   logic                  wr_mask;
   logic [`NLO_IRQ_W-1:0] wdata;
   logic [`NLO_IRQ_W-1:0] stat;
   logic [`NLO_IRQ_W-1:0] mask;
   logic                  irq;

   modport src (output ev, output wr_stat, output wr_mask, output wdata,
                input stat, input mask, input irq);
   modport irq_side (input ev, input wr_stat, input wr_mask, input wdata,
                     output stat, output mask, output irq);
endinterface

// File: rtl/nlo_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module nlo_sync #(
   parameter int              W   = 1,
   parameter logic [W-1:0]    RST = '0
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [W-1:0]  din,
   output      logic [W-1:0]  lvl
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } nlo_sync_st_t;

   nlo_sync_st_t s_r;
   nlo_sync_st_t s_nxt;

   // s1 feeds only s2; a bit moves once s2 and s3 agree
   always_comb begin
      s_nxt     = s_r;
      s_nxt.s1  = din;
      s_nxt.s2  = s_r.s1;
      s_nxt.s3  = s_r.s2;
      s_nxt.lvl = (~(s_r.s2 ^ s_r.s3) & s_r.s3) | ((s_r.s2 ^ s_r.s3) & s_r.lvl);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= {RST, RST, RST, RST};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign lvl = s_r.lvl;
endmodule

// File: rtl/nlo_irq.sv
// sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
module nlo_irq
   import nlo_pkg::*;
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   nlo_if.irq_side    bus
);
   nlo_irq_st_t s_r;
   nlo_irq_st_t s_nxt;

   // an event in the clearing cycle survives: set wins over clear
   always_comb begin
      s_nxt      = s_r;
      s_nxt.stat = (s_r.stat & ~(bus.wr_stat ? bus.wdata : '0)) | bus.ev;
      if (bus.wr_mask) begin
         s_nxt.mask = bus.wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.stat = s_r.stat;
   assign bus.mask = s_r.mask;
   assign bus.irq  = |(s_r.stat & s_r.mask);
endmodule

// File: verif/nlo_top_properties.sv
// concurrent checks on the ports of the near-limit offset block
`timescale 1ns/1ps
module nlo_top_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        load_strobe_a,
   input wire logic        unload_strobe_a,
   input wire logic        offset_prog_enable_n_a,
   input wire logic        fifo_a_clear_n,
   input wire logic        near_limit_flag_a,
   input wire logic        fifo_b_clear_n,
   input wire logic        near_limit_flag_b
);
   // ****
   // quiet-time counter: pins of fifo a still and no bus traffic
   // ****
   logic [3:0] quiet_r;
   logic [3:0] pins_q;
   logic [3:0] pins_now;

   assign pins_now = {load_strobe_a, unload_strobe_a,
                      offset_prog_enable_n_a, fifo_a_clear_n};

   // last sampled pin levels, to spot any change at the next edge
   always_ff @(posedge pclk) begin
      pins_q <= pins_now;
   end

   // seven still cycles cover the three-flop filter plus the flag register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_r <= 4'h0;
      end else if (psel || (pins_now != pins_q)) begin
         quiet_r <= 4'h0;
      end else if (quiet_r != 4'hF) begin
         quiet_r <= quiet_r + 4'h1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ready_fixed_a: assert property (pready)
      else $error("pready low");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   unmapped_err_a: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
      else $error("unmapped access without pslverr");
   mapped_ok_a: assert property (psel && penable && paddr <= 8'h1C && paddr[1:0] == 2'h0
                                 |-> !pslverr)
      else $error("mapped access flagged as error");
   rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("prdata moved outside a setup cycle");
   mask_off_a: assert property (psel && penable && pwrite && paddr == 8'h1C
                                && pwdata[3:0] == 4'h0 |=> !irq)
      else $error("irq high with all sources masked");
   clear_flag_a: assert property (!fifo_a_clear_n [*6] |-> near_limit_flag_a)
      else $error("flag a low during clear");
   clear_b_flag_a: assert property (!fifo_b_clear_n [*6] |-> near_limit_flag_b)
      else $error("flag b low during clear");
   quiet_flag_a: assert property (quiet_r >= 4'h7 |-> $stable(near_limit_flag_a))
      else $error("flag a moved with no cause");
endmodule

bind nlo_top nlo_top_properties nlo_top_properties_i (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .irq, .load_strobe_a, .unload_strobe_a, .offset_prog_enable_n_a,
   .fifo_a_clear_n, .near_limit_flag_a, .fifo_b_clear_n, .near_limit_flag_b
);

// File: verif/nlo_host.sv
// host model driving one fifo's strobes, program enable, clear and low data byte
`timescale 1ns/1ps
module nlo_host (
   input  wire logic       pclk,
   output      logic       ld,
   output      logic       ul,
   output      logic       en_n,
   output      logic       clr_n,
   output      logic [7:0] dat
);
   // ****
   // pin sequences, five cycles per phase and six in a clear, so the filter sees each level
   // ****
   initial begin
      ld = 1'b0;
      ul = 1'b0;
      en_n = 1'b1;
      clr_n = 1'b0;
      dat = 8'hA5;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // strobe stays low across the clear release
   task automatic clear();
      wt(1);
      clr_n <= 1'b0;
      wt(6);
      clr_n <= 1'b1;
      wt(6);
   endtask

   // enable moves only while the strobe is low
   task automatic load(input logic pe_n, input logic [7:0] d);
      wt(1);
      en_n <= pe_n;
      dat  <= d;
      wt(5);
      ld <= 1'b1;
      wt(5);
      ld <= 1'b0;
      wt(5);
      dat <= ~d;   // hold spent: line no longer shows the value
   endtask

   task automatic unload();
      wt(1);
      ul <= 1'b1;
      wt(5);
      ul <= 1'b0;
      wt(5);
   endtask
endmodule

// File: verif/testbench.sv
// self-checking bench for the near-limit offset block
`timescale 1ns/1ps
`include "nlo_cfg.svh"
module testbench;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pslverr, pready, irq, slv;
   logic [7:0]  paddr, d_a, d_b;
   logic [31:0] pwdata, prdata, q;
   logic        ld_a, ul_a, en_a, clr_a, fl_a, ld_b, ul_b, en_b, clr_b, fl_b;
   int          err_count = 0;
   int          n_compared = 0;

   always #25 pclk = ~pclk;

   nlo_top nlo_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .irq, .load_strobe_a(ld_a), .unload_strobe_a(ul_a),
      .offset_prog_enable_n_a(en_a), .fifo_a_clear_n(clr_a), .port_a_low_byte(d_a),
      .near_limit_flag_a(fl_a), .load_strobe_b(ld_b), .unload_strobe_b(ul_b),
      .offset_prog_enable_n_b(en_b), .fifo_b_clear_n(clr_b), .port_b_low_byte(d_b),
      .near_limit_flag_b(fl_b));
   nlo_host nlo_host_a (.pclk, .ld(ld_a), .ul(ul_a), .en_n(en_a), .clr_n(clr_a), .dat(d_a));
   nlo_host nlo_host_b (.pclk, .ld(ld_b), .ul(ul_b), .en_n(en_b), .clr_n(clr_b), .dat(d_b));

   // ****
   // bus and compare helpers
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // no wait count assumed: only the watchdog ends a stuck access
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      slv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ****
   // scenarios
   // ****
   task automatic t_defaults();
      rchk(`NLO_REG_OFFS_A, 32'h8080, 32'hFFFF);
      rchk(`NLO_REG_OFFS_B, 32'h8080, 32'hFFFF);
      rchk(`NLO_REG_STATUS, 32'hF, 32'hF);
      apb(1'b0, 8'h20, 32'h0);
      chk(q, 32'h0);
      chk(slv, 1'b1);
      apb(1'b0, 8'h06, 32'h0);
      chk(slv, 1'b1);
   endtask

   task automatic t_prog_a();
      nlo_host_a.load(1'b0, 8'h05);
      nlo_host_a.load(1'b0, 8'hC8);
      nlo_host_a.load(1'b0, 8'h33);
      rchk(`NLO_REG_OFFS_A, 32'hC805, 32'hFFFF);
      rchk(`NLO_REG_COUNT_A, 32'h0, 32'h3FF);
      for (int i = 1; i <= 6; i++) begin
         nlo_host_a.load(1'b1, 8'h00);
         chk(fl_a, i <= 5);
      end
      nlo_host_a.unload();
      chk(fl_a, 1'b1);
      // late enable after the window shut is deliberate: it must only store a word
      nlo_host_a.load(1'b0, 8'h01);
      chk(fl_a, 1'b0);
      rchk(`NLO_REG_OFFS_A, 32'hC805, 32'hFFFF);
      rchk(`NLO_REG_COUNT_A, 32'h6, 32'h3FF);
      rchk(`NLO_REG_STATUS, 32'h0, 32'h4);
   endtask

   task automatic t_fill_b();
      nlo_host_b.load(1'b0, 8'hFF);
      rchk(`NLO_REG_OFFS_B, 32'hFFFF, 32'hFFFF);
      for (int i = 1; i <= 257; i++) begin
         nlo_host_b.load(1'b1, 8'h3C);
         if (i >= 255) chk(fl_b, i != 256);
      end
      rchk(`NLO_REG_COUNT_B, 32'h101, 32'h3FF);
      apb(1'b1, `NLO_REG_CTRL, 32'h2);
      rchk(`NLO_REG_COUNT_B, 32'h0, 32'h3FF);
      rchk(`NLO_REG_STATUS, 32'hA, 32'hA);
   endtask

   task automatic t_irq();
      apb(1'b1, `NLO_REG_IRQ_STAT, 32'hF);
      rchk(`NLO_REG_IRQ_STAT, 32'h0, 32'hF);
      apb(1'b1, `NLO_REG_CTRL, 32'h1);
      rchk(`NLO_REG_COUNT_A, 32'h0, 32'h3FF);
      rchk(`NLO_REG_OFFS_A, 32'h8080, 32'hFFFF);
      rchk(`NLO_REG_STATUS, 32'h5, 32'h5);
      nlo_host_a.load(1'b0, 8'h10);
      chk(irq, 1'b0);
      rchk(`NLO_REG_IRQ_STAT, 32'h4, 32'h4);
      rchk(`NLO_REG_OFFS_A, 32'h1010, 32'hFFFF);
      apb(1'b1, `NLO_REG_IRQ_MASK, 32'h4);
      chk(irq, 1'b1);
      apb(1'b1, `NLO_REG_IRQ_STAT, 32'h4);
      chk(irq, 1'b0);
      apb(1'b1, `NLO_REG_IRQ_MASK, 32'h0);
      rchk(`NLO_REG_IRQ_STAT, 32'h0, 32'h4);
   endtask

   // ****
   // main sequence and watchdog
   // ****
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      nlo_host_a.clear();
      nlo_host_b.clear();
      t_defaults();
      t_prog_a();
      t_fill_b();
      t_irq();
      close_out();
   end

   // run needs about 4400 cycles; more than five times that before giving up
   initial begin
      repeat (25000) @(posedge pclk);
      err_count++;
      close_out();
   end
endmodule
